// ===== rtl/crs_apb_slave.sv
`timescale 1ns/1ns
// APB3 slave front end with a zero-wait access phase
module crs_apb_slave
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire crs_pkg::crs_apb_t i_apb,
  input wire logic [31:0] i_rdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic o_wr
);
  typedef struct packed {logic [31:0] rdata; logic ready; logic err;} crs_apb_st_t;
  crs_apb_st_t st_reg;
  crs_apb_st_t st_next;
  logic setup;

  assign setup = i_apb.psel && !i_apb.penable && !st_reg.ready;
  assign o_wr = i_apb.psel && i_apb.penable && st_reg.ready && i_apb.pwrite && !st_reg.err;
  assign o_prdata = st_reg.rdata;
  assign o_pready = st_reg.ready;
  assign o_pslverr = st_reg.err;

  // Read data is sampled in the setup cycle
  always_comb
  begin
    st_next = st_reg;
    st_next.ready = 1'b0;
    if (setup)
    begin
      st_next.ready = 1'b1;
      st_next.err = (crs_pkg::reg_decode(i_apb.paddr) == crs_pkg::SEL_NONE);
      st_next.rdata = (st_next.err || i_apb.pwrite) ? crs_pkg::RST_WORD : i_rdata;
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_apb_zero_wait: assert property (setup |=> o_pready ##1 !o_pready)
    else $error("APB access phase not one cycle long");
endmodule : crs_apb_slave

// ===== rtl/crs_core_regs.sv
// Our own choices: the address map and the APB slave port.
`timescale 1ns/1ns
// CPU architectural register set with APB access and interrupt status
// Summary of operation
// RULE1: Sixteen 32-bit general-purpose registers.
// RULE2: Any register serves as data or address.
// RULE3: Register zero is the active stack pointer.
// RULE4: Two stack copies chosen by status select bit.
// RULE5: Select bit zero interrupt stack, one user.
// RULE6: Exception table base locates exception vectors.
// RULE7: Interrupt table base locates interrupt vectors.
// RULE8: Program counter holds current instruction address.
// RULE9: Status word reflects results and CPU state.
// RULE10: Fast interrupt saves program counter to backup.
// RULE11: Fast interrupt saves status word to backup.
// RULE12: Backup status word keeps status bit layout.
// RULE13: Fast interrupt branches to fast vector register.
// RULE14: FP status records each operation's outcome.
// RULE15: Enabled FP exception traps and sets cause.
// RULE16: Masked FP exception sets accumulated flag only.
// RULE17: Accumulated FP flags stay until software clears.
module crs_core_regs
(
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [crs_pkg::AW-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire crs_pkg::crs_gpr_wr_t I_GPR_WR,
  input wire crs_pkg::crs_load_t I_SP_ADJ,
  input wire crs_pkg::crs_load_t I_PC_LD,
  input wire crs_pkg::crs_load_t I_PSW_LD,
  input wire logic I_FINT_ACCEPT,
  input wire logic I_FINT_RETURN,
  input wire logic [3:0] I_RD_A_IDX,
  input wire logic [3:0] I_RD_B_IDX,
  output logic [31:0] O_RD_A_DATA,
  output logic [31:0] O_RD_B_DATA,
  input wire logic [7:0] I_EXC_NUM,
  input wire logic [7:0] I_INT_NUM,
  output logic [31:0] O_EXC_VEC_ADDR,
  output logic [31:0] O_INT_VEC_ADDR,
  output logic [31:0] O_PC,
  output logic [31:0] O_PSW,
  input wire crs_pkg::crs_fp_res_t I_FP_RES,
  output logic [31:0] O_FLOAT_STATUS_WORD,
  output logic O_FP_TRAP,
  output logic O_IRQ
);

  //////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed
  {
    logic [15:1][31:0] gpr;
    logic [31:0] interrupt_stack_pointer;
    logic [31:0] user_stack_pointer;
    logic [31:0] interrupt_table_base;
    logic [31:0] exception_table_base;
    logic [31:0] pc;
    logic [31:0] processor_status_word;
    logic [31:0] backup_program_counter;
    logic [31:0] backup_status_word;
    logic [31:0] fast_interrupt_vector;
    logic [31:0] rd_a;
    logic [31:0] rd_b;
    logic [31:0] exc_vec;
    logic [31:0] int_vec;
    logic [crs_pkg::IRQ_W-1:0] irq_stat;
    logic [crs_pkg::IRQ_W-1:0] irq_en;
    logic irq;
  } crs_core_st_t;

  crs_core_st_t st_reg;
  crs_core_st_t st_next;
  crs_pkg::crs_apb_t apb;
  crs_pkg::crs_sel_t acc_sel;
  logic [3:0] acc_gidx;
  logic apb_wr;
  logic float_status_word_wr;
  logic [31:0] rd_mux;
  logic [31:0] active_sp;
  logic [31:0] sp_new;
  logic sp_touch;
  logic [31:0] exc_off;
  logic [31:0] int_off;
  logic [31:0] float_status_word;
  logic fp_trap;
  logic fp_sticky_ev;
  logic [crs_pkg::IRQ_W-1:0] irq_clr;
  logic [crs_pkg::IRQ_W-1:0] irq_ev;

  // Stack pointer view seen through register zero
  function automatic logic [31:0] gpr_read(input crs_core_st_t s, input logic [3:0] idx,
                                           input logic [31:0] sp);
    logic [31:0] v;
    v = sp;
    if (idx != crs_pkg::GPR_SP)
      v = s.gpr[idx];
    return v;
  endfunction : gpr_read

  //////////////////////////////////////////////////////////////////////////////
  // Register bus

  assign apb = '{psel: I_PSEL, penable: I_PENABLE, pwrite: I_PWRITE, paddr: I_PADDR};
  assign acc_sel = crs_pkg::reg_decode(I_PADDR);
  assign acc_gidx = I_PADDR[crs_pkg::GIDX_LSB +: crs_pkg::GIDX_W];
  assign float_status_word_wr = apb_wr && (acc_sel == crs_pkg::SEL_FLOAT_STATUS_WORD);

  crs_apb_slave u_apb
  (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_apb(apb),
    .i_rdata(rd_mux),
    .o_prdata(O_PRDATA),
    .o_pready(O_PREADY),
    .o_pslverr(O_PSLVERR),
    .o_wr(apb_wr)
  );

  // Clear register is write-only and reads back as zero
  always_comb
  begin
    rd_mux = crs_pkg::RST_WORD;
    case (acc_sel)
      crs_pkg::SEL_GPR: rd_mux = gpr_read(st_reg, acc_gidx, active_sp);
      crs_pkg::SEL_ISP: rd_mux = st_reg.interrupt_stack_pointer;
      crs_pkg::SEL_USP: rd_mux = st_reg.user_stack_pointer;
      crs_pkg::SEL_INTERRUPT_TABLE_BASE: rd_mux = st_reg.interrupt_table_base;
      crs_pkg::SEL_PC: rd_mux = st_reg.pc;
      crs_pkg::SEL_PSW: rd_mux = st_reg.processor_status_word;
      crs_pkg::SEL_BPC: rd_mux = st_reg.backup_program_counter;
      crs_pkg::SEL_BACKUP_STATUS_WORD: rd_mux = st_reg.backup_status_word;
      crs_pkg::SEL_FAST_INTERRUPT_VECTOR: rd_mux = st_reg.fast_interrupt_vector;
      crs_pkg::SEL_FLOAT_STATUS_WORD: rd_mux = float_status_word;
      crs_pkg::SEL_EXCEPTION_TABLE_BASE: rd_mux = st_reg.exception_table_base;
      crs_pkg::SEL_STAT: rd_mux[crs_pkg::IRQ_W-1:0] = st_reg.irq_stat;
      crs_pkg::SEL_EN: rd_mux[crs_pkg::IRQ_W-1:0] = st_reg.irq_en;
      default: rd_mux = crs_pkg::RST_WORD;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Floating-point status

  crs_float_status_word_unit u_float_status_word
  (
    .i_clk(I_CORE_CLK),
    .i_rst(I_SYS_RST),
    .i_wr(float_status_word_wr),
    .i_wdata(I_PWDATA),
    .i_res(I_FP_RES),
    .o_float_status_word(float_status_word),
    .o_trap(fp_trap),
    .o_sticky_ev(fp_sticky_ev)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Next state

  assign active_sp = st_reg.processor_status_word[crs_pkg::PSW_U] ? st_reg.user_stack_pointer : st_reg.interrupt_stack_pointer; // [RULE4] [RULE5]
  assign exc_off = 32'(I_EXC_NUM) * crs_pkg::VEC_BYTES;
  assign int_off = 32'(I_INT_NUM) * crs_pkg::VEC_BYTES;
  assign irq_clr = (apb_wr && acc_sel == crs_pkg::SEL_CLR) ? I_PWDATA[crs_pkg::IRQ_W-1:0] : '0;

  always_comb
  begin
    irq_ev = '0;
    irq_ev[crs_pkg::EV_FINT] = I_FINT_ACCEPT;
    irq_ev[crs_pkg::EV_TRAP] = fp_trap;
    irq_ev[crs_pkg::EV_STICKY] = fp_sticky_ev;
  end

  // Software writes go first so core updates in the same cycle win
  always_comb
  begin
    st_next = st_reg;
    sp_new = active_sp;
    sp_touch = 1'b0;
    if (apb_wr)
    begin
      case (acc_sel)
        crs_pkg::SEL_GPR:
        begin
          if (acc_gidx == crs_pkg::GPR_SP)
          begin
            sp_new = I_PWDATA;
            sp_touch = 1'b1;
          end
          else
            st_next.gpr[acc_gidx] = I_PWDATA;
        end
        crs_pkg::SEL_ISP: st_next.interrupt_stack_pointer = I_PWDATA;
        crs_pkg::SEL_USP: st_next.user_stack_pointer = I_PWDATA;
        crs_pkg::SEL_INTERRUPT_TABLE_BASE: st_next.interrupt_table_base = I_PWDATA;
        crs_pkg::SEL_PC: st_next.pc = I_PWDATA;
        crs_pkg::SEL_PSW: st_next.processor_status_word = I_PWDATA;
        crs_pkg::SEL_BPC: st_next.backup_program_counter = I_PWDATA;
        crs_pkg::SEL_BACKUP_STATUS_WORD: st_next.backup_status_word = I_PWDATA;
        crs_pkg::SEL_FAST_INTERRUPT_VECTOR: st_next.fast_interrupt_vector = I_PWDATA;
        crs_pkg::SEL_EXCEPTION_TABLE_BASE: st_next.exception_table_base = I_PWDATA;
        crs_pkg::SEL_EN: st_next.irq_en = I_PWDATA[crs_pkg::IRQ_W-1:0];
        default: sp_touch = 1'b0;
      endcase
    end

    // Push and pop move the active copy; a core write to register zero beats it
    if (I_SP_ADJ.valid)
    begin
      sp_new = active_sp + I_SP_ADJ.value; // [RULE3]
      sp_touch = 1'b1;
    end
    if (I_GPR_WR.we)
    begin
      if (I_GPR_WR.idx == crs_pkg::GPR_SP)
      begin
        sp_new = I_GPR_WR.data; // [RULE3]
        sp_touch = 1'b1;
      end
      else
        st_next.gpr[I_GPR_WR.idx] = I_GPR_WR.data; // [RULE1] [RULE2]
    end
    if (sp_touch)
    begin
      if (st_reg.processor_status_word[crs_pkg::PSW_U]) // [RULE4] [RULE5]
        st_next.user_stack_pointer = sp_new;
      else
        st_next.interrupt_stack_pointer = sp_new;
    end

    // Fast interrupt skips the stack; handler runs on the interrupt stack
    if (I_FINT_ACCEPT)
    begin
      st_next.backup_program_counter = st_reg.pc; // [RULE10]
      st_next.backup_status_word = st_reg.processor_status_word; // [RULE11] [RULE12]
      st_next.pc = st_reg.fast_interrupt_vector; // [RULE13]
      st_next.processor_status_word[crs_pkg::PSW_U] = 1'b0;
    end
    else if (I_FINT_RETURN)
    begin
      st_next.pc = st_reg.backup_program_counter;
      st_next.processor_status_word = st_reg.backup_status_word; // [RULE12]
    end
    else
    begin
      if (I_PC_LD.valid)
        st_next.pc = I_PC_LD.value; // [RULE8]
      if (I_PSW_LD.valid)
        st_next.processor_status_word = I_PSW_LD.value; // [RULE9]
    end

    // Read ports show register contents before this cycle's writes
    st_next.rd_a = gpr_read(st_reg, I_RD_A_IDX, active_sp); // [RULE2]
    st_next.rd_b = gpr_read(st_reg, I_RD_B_IDX, active_sp); // [RULE2]
    st_next.exc_vec = st_reg.exception_table_base + exc_off; // [RULE6]
    st_next.int_vec = st_reg.interrupt_table_base + int_off; // [RULE7]

    // A new event beats a clear in the same cycle
    st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_ev;
    st_next.irq = |(st_next.irq_stat & st_next.irq_en);
  end

  always_ff @(posedge I_CORE_CLK)
  begin
    if (I_SYS_RST)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign O_RD_A_DATA = st_reg.rd_a;
  assign O_RD_B_DATA = st_reg.rd_b;
  assign O_EXC_VEC_ADDR = st_reg.exc_vec;
  assign O_INT_VEC_ADDR = st_reg.int_vec;
  assign O_PC = st_reg.pc;
  assign O_PSW = st_reg.processor_status_word;
  assign O_FLOAT_STATUS_WORD = float_status_word;
  assign O_FP_TRAP = fp_trap;
  assign O_IRQ = st_reg.irq;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (I_SYS_RST);

  sequence s_gpr_wr;
    I_GPR_WR.we && I_GPR_WR.idx != crs_pkg::GPR_SP && !apb_wr;
  endsequence

  sequence s_fint_then_ret;
    (I_FINT_ACCEPT && !apb_wr) ##1 (I_FINT_RETURN && !I_FINT_ACCEPT && !apb_wr);
  endsequence

  chk_gpr_write_read: assert property ( // [RULE1]
    s_gpr_wr ##1 (I_RD_A_IDX == $past(I_GPR_WR.idx) && !I_GPR_WR.we && !apb_wr)
    |=> O_RD_A_DATA == $past(I_GPR_WR.data, 2))
    else $error("General register lost its written value");
  chk_sp_alias: assert property ((I_RD_B_IDX == crs_pkg::GPR_SP) |=> O_RD_B_DATA == $past(active_sp)) // [RULE3]
    else $error("Register zero does not show the stack pointer");
  chk_sp_bank: assert property ( // [RULE4]
    (I_SP_ADJ.valid && !st_reg.processor_status_word[crs_pkg::PSW_U] && !I_GPR_WR.we && !apb_wr)
    |=> st_reg.interrupt_stack_pointer == $past(st_reg.interrupt_stack_pointer) + $past(I_SP_ADJ.value) && $stable(st_reg.user_stack_pointer))
    else $error("Stack adjust hit the wrong stack copy");
  chk_sp_user_bank: assert property ( // [RULE4]
    (I_SP_ADJ.valid && st_reg.processor_status_word[crs_pkg::PSW_U] && !I_GPR_WR.we && !apb_wr)
    |=> st_reg.user_stack_pointer == $past(st_reg.user_stack_pointer) + $past(I_SP_ADJ.value) && $stable(st_reg.interrupt_stack_pointer))
    else $error("Stack adjust missed the user stack copy");
  chk_exc_base: assert property (##1 O_EXC_VEC_ADDR == $past(st_reg.exception_table_base) + $past(exc_off)) // [RULE6]
    else $error("Exception vector address not from table base");
  chk_int_base: assert property (##1 O_INT_VEC_ADDR == $past(st_reg.interrupt_table_base) + $past(int_off)) // [RULE7]
    else $error("Interrupt vector address not from table base");
  chk_pc_load: assert property ((I_PC_LD.valid && !I_FINT_ACCEPT && !I_FINT_RETURN) // [RULE8]
    |=> O_PC == $past(I_PC_LD.value))
    else $error("Program counter did not load");
  chk_psw_load: assert property ((I_PSW_LD.valid && !I_FINT_ACCEPT && !I_FINT_RETURN) // [RULE9]
    |=> O_PSW == $past(I_PSW_LD.value))
    else $error("Status word did not load");
  chk_fint_save: assert property ((I_FINT_ACCEPT && !apb_wr) // [RULE10] [RULE11]
    |=> st_reg.backup_program_counter == $past(O_PC) && st_reg.backup_status_word == $past(O_PSW))
    else $error("Fast interrupt backup copies wrong");
  chk_fint_branch: assert property (I_FINT_ACCEPT // [RULE13]
    |=> O_PC == $past(st_reg.fast_interrupt_vector) && !O_PSW[crs_pkg::PSW_U])
    else $error("Fast interrupt did not branch to its vector");
  chk_fint_round_trip: assert property (s_fint_then_ret |=> O_PC == $past(O_PC, 2)) // [RULE10]
    else $error("Return from fast interrupt lost the program counter");
  chk_fint_restore: assert property ((I_FINT_RETURN && !I_FINT_ACCEPT) // [RULE12]
    |=> O_PSW == $past(st_reg.backup_status_word) && O_PC == $past(st_reg.backup_program_counter))
    else $error("Return from fast interrupt did not restore state");
  chk_irq_level: assert property (O_IRQ == |(st_reg.irq_stat & st_reg.irq_en))
    else $error("Interrupt output disagrees with status and enable");
  chk_irq_set_wins: assert property (I_FINT_ACCEPT |=> st_reg.irq_stat[crs_pkg::EV_FINT])
    else $error("Event lost against a same-cycle clear");
endmodule : crs_core_regs

// ===== rtl/crs_float_status_word_unit.sv
`timescale 1ns/1ns
// Floating-point status word with cause, enable and sticky flags
module crs_float_status_word_unit
(
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_wr,
  input wire logic [31:0] i_wdata,
  input wire crs_pkg::crs_fp_res_t i_res,
  output logic [31:0] o_float_status_word,
  output logic o_trap,
  output logic o_sticky_ev
);
  typedef struct packed {logic [31:0] float_status_word; logic trap; logic ev;} crs_fp_st_t;
  crs_fp_st_t st_reg;
  crs_fp_st_t st_next;
  logic [crs_pkg::EXC_W-1:0] en;
  logic [crs_pkg::EXC_W-1:0] cause;
  logic [crs_pkg::EXC_W-1:0] set;
  logic [crs_pkg::EXC_W-1:0] sticky;

  assign en = st_reg.float_status_word[crs_pkg::FLOAT_STATUS_WORD_E +: crs_pkg::EXC_W];
  assign sticky = st_reg.float_status_word[crs_pkg::FLOAT_STATUS_WORD_F +: crs_pkg::EXC_W];
  assign cause = i_res.exc & en;
  assign set = i_res.exc & ~en;
  assign o_float_status_word = st_reg.float_status_word;
  assign o_trap = st_reg.trap;
  assign o_sticky_ev = st_reg.ev;

  always_comb
  begin
    st_next = st_reg;
    st_next.trap = 1'b0;
    st_next.ev = 1'b0;
    // Writing 1 to a sticky flag keeps it, writing 0 clears it
    if (i_wr)
      st_next.float_status_word = (i_wdata & crs_pkg::FLOAT_STATUS_WORD_WMASK) | (st_reg.float_status_word & i_wdata & crs_pkg::FLOAT_STATUS_WORD_FMASK); // [RULE17]
    if (i_res.valid)
    begin
      st_next.float_status_word[crs_pkg::FLOAT_STATUS_WORD_C +: crs_pkg::EXC_W] = cause; // [RULE14] [RULE15]
      st_next.float_status_word[crs_pkg::FLOAT_STATUS_WORD_F +: crs_pkg::EXC_W] =
        st_next.float_status_word[crs_pkg::FLOAT_STATUS_WORD_F +: crs_pkg::EXC_W] | set; // [RULE16] [RULE17]
      st_next.trap = |cause; // [RULE15]
      st_next.ev = |(set & ~sticky);
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (i_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  chk_fp_cause_trap: assert property (i_res.valid |=> // [RULE15]
    o_float_status_word[crs_pkg::FLOAT_STATUS_WORD_C +: crs_pkg::EXC_W] == $past(cause) && o_trap == |$past(cause))
    else $error("FP cause flags or trap wrong");
  chk_fp_sticky_set: assert property (i_res.valid |=> // [RULE16]
    (o_float_status_word[crs_pkg::FLOAT_STATUS_WORD_F +: crs_pkg::EXC_W] & $past(set)) == $past(set))
    else $error("Masked FP exception not accumulated");
  chk_fp_sticky_hold: assert property (!i_wr |=> (sticky & $past(sticky)) == $past(sticky)) // [RULE17]
    else $error("Sticky FP flag dropped without software clear");
endmodule : crs_float_status_word_unit

// ===== rtl/crs_pkg.sv
// Constants, register map and carrier types of the CPU register set
package crs_pkg;
  localparam int XLEN = 32;
  localparam int AW = 8;
  localparam int EXC_W = 5;
  localparam int IRQ_W = 3;
  localparam int GIDX_LSB = 2;
  localparam int GIDX_W = 4;
  localparam logic [3:0] GPR_SP = 4'h0;
  localparam logic [31:0] VEC_BYTES = 32'h0000_0004;
  localparam int PSW_U = 17;
  localparam int EV_FINT = 0;
  localparam int EV_TRAP = 1;
  localparam int EV_STICKY = 2;
  localparam int FLOAT_STATUS_WORD_C = 2;
  localparam int FLOAT_STATUS_WORD_E = 10;
  localparam int FLOAT_STATUS_WORD_F = 26;
  localparam logic [31:0] FLOAT_STATUS_WORD_WMASK = 32'h0000_7C7F;
  localparam logic [31:0] FLOAT_STATUS_WORD_FMASK = 32'h7C00_0000;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam logic [AW-1:0] A_ISP = 8'h40;
  localparam logic [AW-1:0] A_USP = 8'h44;
  localparam logic [AW-1:0] A_INTERRUPT_TABLE_BASE = 8'h48;
  localparam logic [AW-1:0] A_PC = 8'h4C;
  localparam logic [AW-1:0] A_PSW = 8'h50;
  localparam logic [AW-1:0] A_BPC = 8'h54;
  localparam logic [AW-1:0] A_BACKUP_STATUS_WORD = 8'h58;
  localparam logic [AW-1:0] A_FAST_INTERRUPT_VECTOR = 8'h5C;
  localparam logic [AW-1:0] A_FLOAT_STATUS_WORD = 8'h60;
  localparam logic [AW-1:0] A_EXCEPTION_TABLE_BASE = 8'h64;
  localparam logic [AW-1:0] A_STAT = 8'h68;
  localparam logic [AW-1:0] A_CLR = 8'h6C;
  localparam logic [AW-1:0] A_EN = 8'h70;

  typedef enum logic [3:0] {SEL_GPR, SEL_ISP, SEL_USP, SEL_INTERRUPT_TABLE_BASE, SEL_PC, SEL_PSW, SEL_BPC,
    SEL_BACKUP_STATUS_WORD, SEL_FAST_INTERRUPT_VECTOR, SEL_FLOAT_STATUS_WORD, SEL_EXCEPTION_TABLE_BASE, SEL_STAT, SEL_CLR, SEL_EN, SEL_NONE} crs_sel_t;

  typedef struct packed {logic psel; logic penable; logic pwrite; logic [AW-1:0] paddr;} crs_apb_t;
  typedef struct packed {logic we; logic [3:0] idx; logic [31:0] data;} crs_gpr_wr_t;
  typedef struct packed {logic valid; logic [31:0] value;} crs_load_t;
  typedef struct packed {logic valid; logic [EXC_W-1:0] exc;} crs_fp_res_t;

  function automatic crs_sel_t reg_decode(input logic [AW-1:0] a);
    crs_sel_t s;
    s = SEL_NONE;
    if (a[GIDX_LSB-1:0] != 2'h0)
      s = SEL_NONE;
    else if (a < A_ISP)
      s = SEL_GPR;
    else
      case (a)
        A_ISP: s = SEL_ISP;
        A_USP: s = SEL_USP;
        A_INTERRUPT_TABLE_BASE: s = SEL_INTERRUPT_TABLE_BASE;
        A_PC: s = SEL_PC;
        A_PSW: s = SEL_PSW;
        A_BPC: s = SEL_BPC;
        A_BACKUP_STATUS_WORD: s = SEL_BACKUP_STATUS_WORD;
        A_FAST_INTERRUPT_VECTOR: s = SEL_FAST_INTERRUPT_VECTOR;
        A_FLOAT_STATUS_WORD: s = SEL_FLOAT_STATUS_WORD;
        A_EXCEPTION_TABLE_BASE: s = SEL_EXCEPTION_TABLE_BASE;
        A_STAT: s = SEL_STAT;
        A_CLR: s = SEL_CLR;
        A_EN: s = SEL_EN;
        default: s = SEL_NONE;
      endcase
    return s;
  endfunction : reg_decode
endpackage : crs_pkg

// ===== verif/tb_top.sv
// Self-checking bench of the CPU register set
`timescale 1ns/1ns
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [crs_pkg::AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  crs_pkg::crs_gpr_wr_t gwr_s = '0;
  crs_pkg::crs_load_t adj_s = '0;
  crs_pkg::crs_load_t pcl_s = '0;
  crs_pkg::crs_load_t stl_s = '0;
  crs_pkg::crs_fp_res_t fp_s = '0;
  logic fint_acc = 1'b0;
  logic fint_ret = 1'b0;
  logic [3:0] rda = '0;
  logic [3:0] rdb = '0;
  logic [7:0] exc_num = '0;
  logic [7:0] int_num = '0;
  logic [31:0] prdata, rd_a_data, rd_b_data, exc_vec, int_vec, cur_prog, cur_stat, fp_word;
  logic pready, pslverr, fp_trap, irq;
  int bad_count = 0;
  int n_checks = 0;
  int seed = 76378;
  int cycles = 0;

  crs_core_regs i_dut
  (
    .I_CORE_CLK(clk), .I_SYS_RST(rst), .I_PSEL(psel), .I_PENABLE(penable), .I_PWRITE(pwrite),
    .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_GPR_WR(gwr_s), .I_SP_ADJ(adj_s), .I_PC_LD(pcl_s), .I_PSW_LD(stl_s), .I_FINT_ACCEPT(fint_acc),
    .I_FINT_RETURN(fint_ret), .I_RD_A_IDX(rda), .I_RD_B_IDX(rdb), .O_RD_A_DATA(rd_a_data),
    .O_RD_B_DATA(rd_b_data), .I_EXC_NUM(exc_num), .I_INT_NUM(int_num), .O_EXC_VEC_ADDR(exc_vec),
    .O_INT_VEC_ADDR(int_vec), .O_PC(cur_prog), .O_PSW(cur_stat), .I_FP_RES(fp_s), .O_FLOAT_STATUS_WORD(fp_word),
    .O_FP_TRAP(fp_trap), .O_IRQ(irq)
  );

  initial forever #4 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Hang guard, well above the few hundred cycles of the run
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count = bad_count + 1;
      final_report();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  function automatic logic [31:0] rnd();
    return $random(seed);
  endfunction : rnd

  function automatic logic [31:0] fpw(logic [4:0] c, logic [4:0] en, logic [4:0] s);
    return {1'b0, s, 11'h0, en, 3'h0, c, 2'h0};
  endfunction : fpw

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
    output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    check(q, x);
  endtask : rdc

  task automatic gw(input logic [3:0] i, input logic [31:0] d);
    @(posedge clk);
    gwr_s <= {1'b1, i, d};
    rda <= i;
    @(posedge clk);
    gwr_s.we <= 1'b0;
  endtask : gw

  task automatic rdp(input logic [3:0] i, input logic [31:0] x);
    @(posedge clk);
    rda <= i;
    rdb <= i;
    repeat (2) @(posedge clk);
    check(rd_a_data, x);
    check(rd_b_data, x);
  endtask : rdp

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [31:0] gv, di, du, k, v, pv, fv, eb, ib, q;
    logic [7:0] en8, in8;
    logic [4:0] en, ex, cz, stk, nw, wst;
    logic [2:0] st;
    logic e;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check(cur_prog, 32'h0000_0000);
    check(cur_stat, 32'h0000_0000);
    check(fp_word, 32'h0000_0000);
    for (int i = 1; i < 16; i++)
    begin
      gv = rnd();
      gw(i[3:0], gv);
      rdp(i[3:0], gv);
      rdc({i[5:0], 2'b00}, gv);
    end
    gv = rnd();
    wr(8'h3C, gv);
    rdp(4'hF, gv);
    // Stack copies follow the select bit
    di = rnd();
    gw(4'h0, di);
    rdc(crs_pkg::A_ISP, di);
    v = rnd() | 32'h0002_0000;
    @(posedge clk);
    stl_s <= {1'b1, v};
    @(posedge clk);
    stl_s.valid <= 1'b0;
    @(posedge clk);
    check(cur_stat, v);
    du = rnd();
    gw(4'h0, du);
    rdc(crs_pkg::A_USP, du);
    rdc(crs_pkg::A_ISP, di);
    k = rnd();
    @(posedge clk);
    adj_s <= {1'b1, k};
    @(posedge clk);
    adj_s.valid <= 1'b0;
    rdp(4'h0, du + k);
    for (int j = 0; j < 3; j++)
    begin
      eb = rnd();
      ib = rnd();
      en8 = (j == 0) ? 8'hFF : 8'(rnd());
      in8 = (j == 0) ? 8'hFF : 8'(rnd());
      wr(crs_pkg::A_EXCEPTION_TABLE_BASE, eb);
      wr(crs_pkg::A_INTERRUPT_TABLE_BASE, ib);
      exc_num <= en8;
      int_num <= in8;
      repeat (3) @(posedge clk);
      check(exc_vec, eb + {22'h0, en8, 2'b00});
      check(int_vec, ib + {22'h0, in8, 2'b00});
    end
    // Fast interrupt entry, return, then with its event masked
    fv = rnd();
    pv = rnd();
    wr(crs_pkg::A_FAST_INTERRUPT_VECTOR, fv);
    wr(crs_pkg::A_EN, 32'h0000_0001);
    @(posedge clk);
    pcl_s <= {1'b1, pv};
    @(posedge clk);
    pcl_s.valid <= 1'b0;
    @(posedge clk);
    check(cur_prog, pv);
    fint_acc <= 1'b1;
    @(posedge clk);
    fint_acc <= 1'b0;
    repeat (2) @(posedge clk);
    check(cur_prog, fv);
    check({31'h0, cur_stat[crs_pkg::PSW_U]}, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0001);
    rdc(crs_pkg::A_BPC, pv);
    rdc(crs_pkg::A_BACKUP_STATUS_WORD, v);
    rdp(4'h0, di);
    // Adjust while the interrupt copy is active
    k = rnd();
    @(posedge clk);
    adj_s <= {1'b1, k};
    @(posedge clk);
    adj_s.valid <= 1'b0;
    rdp(4'h0, di + k);
    wr(crs_pkg::A_CLR, 32'h0000_0001);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0000_0000);
    fint_ret <= 1'b1;
    @(posedge clk);
    fint_ret <= 1'b0;
    @(posedge clk);
    check(cur_prog, pv);
    check(cur_stat, v);
    wr(crs_pkg::A_EN, 32'h0000_0000);
    fint_acc <= 1'b1;
    @(posedge clk);
    fint_acc <= 1'b0;
    wr(crs_pkg::A_STAT, 32'h0000_0000);
    rdc(crs_pkg::A_STAT, 32'h0000_0001);
    check({31'h0, irq}, 32'h0000_0000);
    wr(crs_pkg::A_CLR, 32'h0000_0007);
    rdc(crs_pkg::A_STAT, 32'h0000_0000);
    // Refused addresses answer with an error and no data
    apb(1'b0, 8'h74, 32'h0000_0000, q, e);
    check(q, 32'h0000_0000);
    check({31'h0, e}, 32'h0000_0001);
    apb(1'b1, 8'h41, 32'hFFFF_FFFF, q, e);
    check({31'h0, e}, 32'h0000_0001);
    rdc(crs_pkg::A_CLR, 32'h0000_0000);
    // Floating-point flags: cause for enabled types, sticky for masked ones
    wr(crs_pkg::A_EN, 32'h0000_0006);
    stk = 5'h00;
    st = 3'h0;
    for (int j = 0; j < 6; j++)
    begin
      en = (j == 0) ? 5'h00 : (j == 1) ? 5'h1F : 5'(rnd());
      wst = (j == 3) ? 5'h00 : 5'h1F;
      wr(crs_pkg::A_FLOAT_STATUS_WORD, fpw(5'h00, en, wst));
      stk = stk & wst;
      rdc(crs_pkg::A_FLOAT_STATUS_WORD, fpw(5'h00, en, stk));
      for (int n = 0; n < 3; n++)
      begin
        ex = (n == 0) ? 5'h1F : (n == 2) ? 5'h00 : 5'(rnd());
        @(posedge clk);
        fp_s <= {1'b1, ex};
        @(posedge clk);
        fp_s.valid <= 1'b0;
        @(posedge clk);
        cz = ex & en;
        nw = ex & ~en & ~stk;
        stk = stk | (ex & ~en);
        st = st | {|nw, |cz, 1'b0};
        check({31'h0, fp_trap}, {31'h0, |cz});
        check(fp_word, fpw(cz, en, stk));
      end
      rdc(crs_pkg::A_STAT, {29'h0, st});
      check({31'h0, irq}, {31'h0, |st});
    end
    // Return right behind the accept must restore the loaded counter
    pv = rnd();
    pcl_s <= {1'b1, pv};
    @(posedge clk);
    pcl_s.valid <= 1'b0;
    fint_acc <= 1'b1;
    @(posedge clk);
    fint_acc <= 1'b0;
    fint_ret <= 1'b1;
    @(posedge clk);
    fint_ret <= 1'b0;
    @(posedge clk);
    check(cur_prog, pv);
    final_report();
  end
endmodule : tb_top
